/* hdl/dsm_lane_mapper.sv */
/*
   Sample lane mapper: places one frame of decimated or bypass samples onto
   sixteen output lanes (a0..a7 at index 0..7, b0..b7 at index 8..15) and
   holds the result in a two-entry buffer toward the framer.
   Assumes one input frame per accepted valid, mode stable with its data,
   and a downstream framer that may stall with lane_ready_i.
   limitation: the mode is decoded on the input side, so a frame and its
   mode must be offered together; a mode change between frames is free.
   unlisted modes still pass through the buffer as empty frames, which
   keeps the output frame count equal to the input frame count.
   lanes a0..a7 and b0..b7 are the two halves of the lane port.
*/
`timescale 1ns/1ps
`include "dsm_params.svh"

module dsm_lane_mapper (
   // clock and reset
   input  wire logic                                  clk_sys_i,
   input  wire logic                                  rstn_i,
   // frame in: mode and samples
   input  wire logic                                  in_valid_i,
   output logic                                       in_ready_o,
   input  wire dsm_pkg::dsm_mode_t                    link_mode_select_i,
   input  wire logic [`DSM_COMP_N-1:0][`DSM_SAMP_W-1:0] chan_a_inphase_i,
   input  wire logic [`DSM_COMP_N-1:0][`DSM_SAMP_W-1:0] chan_a_quadrature_i,
   input  wire logic [`DSM_COMP_N-1:0][`DSM_SAMP_W-1:0] chan_b_inphase_i,
   input  wire logic [`DSM_COMP_N-1:0][`DSM_SAMP_W-1:0] chan_b_quadrature_i,
   input  wire logic [`DSM_COMP_N-1:0]                chan_a_inphase_overrange_i,
   input  wire logic [`DSM_COMP_N-1:0]                chan_a_quad_overrange_i,
   input  wire logic [`DSM_COMP_N-1:0]                chan_b_inphase_overrange_i,
   input  wire logic [`DSM_COMP_N-1:0]                chan_b_quad_overrange_i,
   input  wire logic [`DSM_BYP_N-1:0][`DSM_BYP_W-1:0]  byp_a_i,
   input  wire logic [`DSM_BYP_N-1:0][`DSM_BYP_W-1:0]  byp_b_i,
   // frame out: lanes toward the framer
   output logic                                       lane_valid_o,
   input  wire logic                                  lane_ready_i,
   output logic [`DSM_LANE_N-1:0][`DSM_LANE_W-1:0]    lane_data_o,
   output logic [`DSM_LANE_N-1:0]                     lane_used_o,
   output logic                                       lane_unmapped_o
);
   import dsm_pkg::*;
   // types and the mapping family enum come from the package

   // sample and flag to one lane word, msb-first, low half left empty
   // the low half stays zero so that every 16-bit mode except the two-lane dual modes leaves octets 2 and 3 idle
   function automatic dsm_lane_t lane_word(input dsm_samp_t s, input logic f);
      lane_word = {s, f, {`DSM_PAD_W{1'b0}}};
   endfunction

   // upper half of a lane for three-lane bypass packing
   function automatic dsm_lane_t byp_lane(input logic [`DSM_WORD_W-1:0] w);
      byp_lane = {w, {`DSM_PAD_W{1'b0}}};
   endfunction

   // mode number to mapping family
   // the numbers are decimal link modes held as 7-bit values
   // anything outside the listed numbers falls to the unmapped family
   function automatic dsm_map_e classify(input dsm_mode_t m);
      case (m)
         `DSM_LM_13, `DSM_LM_39, `DSM_LM_56, `DSM_LM_59, `DSM_LM_66,
         `DSM_LM_68: classify = DSM_DUAL_2L;
         `DSM_LM_14, `DSM_LM_49, `DSM_LM_57, `DSM_LM_60,
         `DSM_LM_67: classify = DSM_DUAL_4L;
         `DSM_LM_15, `DSM_LM_55, `DSM_LM_58: classify = DSM_DUAL_8L;
         `DSM_LM_16: classify = DSM_DUAL_16L;
         `DSM_LM_19, `DSM_LM_42: classify = DSM_BYP_SINGLE;
         `DSM_LM_20, `DSM_LM_43: classify = DSM_BYP_DUAL;
         `DSM_LM_21, `DSM_LM_36: classify = DSM_SING_D4_4L;
         `DSM_LM_22, `DSM_LM_46: classify = DSM_SING_D4_8L;
         `DSM_LM_23, `DSM_LM_38, `DSM_LM_61, `DSM_LM_64, `DSM_LM_69,
         `DSM_LM_71: classify = DSM_SING_D8_2L;
         `DSM_LM_24, `DSM_LM_48, `DSM_LM_62, `DSM_LM_65,
         `DSM_LM_70: classify = DSM_SING_D8_4L;
         default: classify = DSM_UNMAPPED;
      endcase
   endfunction

   // lanes used on each side per family
   // bypass fills six lanes per side, three per group of four samples
   function automatic logic [3:0] side_lanes(input dsm_map_e c);
      case (c)
         DSM_DUAL_2L, DSM_SING_D8_2L: side_lanes = `DSM_LANES_1;
         DSM_DUAL_4L, DSM_SING_D4_4L, DSM_SING_D8_4L: side_lanes = `DSM_LANES_2;
         DSM_DUAL_8L, DSM_SING_D4_8L: side_lanes = `DSM_LANES_4;
         DSM_DUAL_16L: side_lanes = `DSM_LANES_8;
         DSM_BYP_SINGLE, DSM_BYP_DUAL: side_lanes = `DSM_LANES_6;
         default: side_lanes = `DSM_WORDS_0;
      endcase
   endfunction

   // words of each component placed on one side
   // two-lane dual modes return zero here; they are packed separately below
   function automatic logic [3:0] comp_words(input dsm_map_e c);
      case (c)
         DSM_DUAL_4L, DSM_SING_D8_2L: comp_words = `DSM_WORDS_1;
         DSM_DUAL_8L, DSM_SING_D4_4L, DSM_SING_D8_4L: comp_words = `DSM_WORDS_2;
         DSM_DUAL_16L, DSM_SING_D4_8L: comp_words = `DSM_WORDS_4;
         default: comp_words = `DSM_WORDS_0;
      endcase
   endfunction

   // decode of the incoming mode
   // all decode is combinational on the offered mode, so the mode must be
   // held with in_valid_i until the frame is taken
   dsm_map_e   map_cls;
   logic [3:0] map_side_n;
   logic [3:0] map_words;
   logic       map_dual;
   logic       map_sing;
   logic       map_byp;
   logic       map_none;

   assign map_cls    = classify(link_mode_select_i);
   assign map_side_n = side_lanes(map_cls);
   assign map_words  = comp_words(map_cls);
   assign map_dual   = (map_cls == DSM_DUAL_4L) || (map_cls == DSM_DUAL_8L) ||
                       (map_cls == DSM_DUAL_16L);
   assign map_sing   = (map_cls == DSM_SING_D4_4L) || (map_cls == DSM_SING_D4_8L) ||
                       (map_cls == DSM_SING_D8_2L) || (map_cls == DSM_SING_D8_4L);
   assign map_byp    = (map_cls == DSM_BYP_SINGLE) || (map_cls == DSM_BYP_DUAL);
   // unmapped frames are still buffered so that frame counts stay paired
   assign map_none   = (map_cls == DSM_UNMAPPED);

   // bypass groups: four samples over three lanes, concatenation is msb-first
   // byp_a_i holds even samples (single) or channel A (dual); the packing is
   // the same, so one set of groups serves both bypass modes
   logic [3*`DSM_WORD_W-1:0] grp_a0;
   logic [3*`DSM_WORD_W-1:0] grp_a1;
   logic [3*`DSM_WORD_W-1:0] grp_b0;
   logic [3*`DSM_WORD_W-1:0] grp_b1;

   assign grp_a0 = {byp_a_i[0], byp_a_i[1], byp_a_i[2], byp_a_i[3]};
   assign grp_a1 = {byp_a_i[4], byp_a_i[5], byp_a_i[6], byp_a_i[7]};
   assign grp_b0 = {byp_b_i[0], byp_b_i[1], byp_b_i[2], byp_b_i[3]};
   assign grp_b1 = {byp_b_i[4], byp_b_i[5], byp_b_i[6], byp_b_i[7]};

   // lane contents of the incoming frame
   // zero means an idle lane; used flags tell real zeros from idle lanes
   logic [`DSM_LANE_N-1:0][`DSM_LANE_W-1:0] map_lane;
   logic [`DSM_LANE_N-1:0]                  map_used;

   // later assignments win: the two-lane and bypass packings override the
   // per-lane loop, and unlisted modes keep the zero defaults
   always_comb begin
      map_lane = '0;
      map_used = '0;
      // lane index i on side a, i plus the side count on side b
      for (int i = 0; i < `DSM_SIDE_N; i++) begin
         if (4'(i) < map_side_n) begin
            map_used[i]               = 1'b1;
            map_used[i + `DSM_SIDE_N] = 1'b1;
         end
         // a side I words then Q words
         if (map_dual && (4'(i) < map_words)) begin
            map_lane[i] = lane_word(chan_a_inphase_i[2'(i)],
                                    chan_a_inphase_overrange_i[2'(i)]);
            map_lane[i + `DSM_SIDE_N] = lane_word(chan_b_inphase_i[2'(i)],
                                    chan_b_inphase_overrange_i[2'(i)]);
         end else if (map_dual && (4'(i) < 4'(map_words << 1))) begin
            map_lane[i] = lane_word(chan_a_quadrature_i[2'(i - int'(map_words))],
                                    chan_a_quad_overrange_i[2'(i - int'(map_words))]);
            map_lane[i + `DSM_SIDE_N] =
               lane_word(chan_b_quadrature_i[2'(i - int'(map_words))],
                         chan_b_quad_overrange_i[2'(i - int'(map_words))]);
         end
         // I on a side, Q on b side
         if (map_sing && (4'(i) < map_words)) begin
            map_lane[i] = lane_word(chan_a_inphase_i[2'(i)],
                                    chan_a_inphase_overrange_i[2'(i)]);
            map_lane[i + `DSM_SIDE_N] = lane_word(chan_a_quadrature_i[2'(i)],
                                    chan_a_quad_overrange_i[2'(i)]);
         end
      end
      // two words back to back per lane
      // both 16-bit words share one 32-bit lane, in-phase word in octets 0-1
      if (map_cls == DSM_DUAL_2L) begin
         map_lane[0] = {lane_word(chan_a_inphase_i[0], chan_a_inphase_overrange_i[0])
                           [`DSM_LANE_W-1:`DSM_PAD_W],
                        lane_word(chan_a_quadrature_i[0], chan_a_quad_overrange_i[0])
                           [`DSM_LANE_W-1:`DSM_PAD_W]};
         map_lane[`DSM_SIDE_N] =
                       {lane_word(chan_b_inphase_i[0], chan_b_inphase_overrange_i[0])
                           [`DSM_LANE_W-1:`DSM_PAD_W],
                        lane_word(chan_b_quadrature_i[0], chan_b_quad_overrange_i[0])
                           [`DSM_LANE_W-1:`DSM_PAD_W]};
      end
      // groups onto lanes 0-2 and 3-5
      // lane g of each three-lane group takes 16-bit slice 2-g, so the msb slice comes first
      if (map_byp) begin
         for (int g = 0; g < 3; g++) begin
            map_lane[g] = byp_lane(grp_a0[(2-g)*`DSM_WORD_W +: `DSM_WORD_W]);
            map_lane[g + 3] = byp_lane(grp_a1[(2-g)*`DSM_WORD_W +: `DSM_WORD_W]);
            map_lane[g + `DSM_SIDE_N] =
               byp_lane(grp_b0[(2-g)*`DSM_WORD_W +: `DSM_WORD_W]);
            map_lane[g + 3 + `DSM_SIDE_N] =
               byp_lane(grp_b1[(2-g)*`DSM_WORD_W +: `DSM_WORD_W]);
         end
      end
   end

   // two-entry buffer: head drives the ports, tail catches a word during a stall
   // a stalled head never changes; the tail absorbs exactly one more frame
   logic [`DSM_LANE_N-1:0][`DSM_LANE_W-1:0] hd_data_r;
   logic [`DSM_LANE_N-1:0][`DSM_LANE_W-1:0] tl_data_r;
   logic [`DSM_LANE_N-1:0][`DSM_LANE_W-1:0] hd_data_nxt;
   logic [`DSM_LANE_N-1:0][`DSM_LANE_W-1:0] tl_data_nxt;
   logic [`DSM_LANE_N-1:0]                  hd_used_r;
   logic [`DSM_LANE_N-1:0]                  tl_used_r;
   logic [`DSM_LANE_N-1:0]                  hd_used_nxt;
   logic [`DSM_LANE_N-1:0]                  tl_used_nxt;
   logic                                    hd_none_r;
   logic                                    tl_none_r;
   logic                                    hd_none_nxt;
   logic                                    tl_none_nxt;
   logic                                    hd_vld_r;
   logic                                    tl_vld_r;
   logic                                    hd_vld_nxt;
   logic                                    tl_vld_nxt;

   logic                                    rdy_r;
   logic                                    push;
   logic                                    pop;

   // ready is registered, so it only depends on the tail being empty
   // the cost of a registered ready is that no frame is taken in the cycle a pop frees the tail
   assign push = in_valid_i && rdy_r;
   assign pop  = hd_vld_r && lane_ready_i;

   // buffer steering
   // a pop promotes the tail first, then a push lands in the freed slot;
   // a push and a full tail never meet because ready is low whenever the
   // tail holds a frame
   always_comb begin
      hd_data_nxt = hd_data_r;
      hd_used_nxt = hd_used_r;
      hd_none_nxt = hd_none_r;
      hd_vld_nxt  = hd_vld_r;
      tl_data_nxt = tl_data_r;
      tl_used_nxt = tl_used_r;
      tl_none_nxt = tl_none_r;
      tl_vld_nxt  = tl_vld_r;
      if (pop && tl_vld_r) begin
         hd_data_nxt = tl_data_r;
         hd_used_nxt = tl_used_r;
         hd_none_nxt = tl_none_r;
         tl_vld_nxt  = 1'b0;
      end else if (pop) begin
         hd_vld_nxt = 1'b0;
      end
      if (push && (!hd_vld_r || pop)) begin
         hd_data_nxt = map_lane;
         hd_used_nxt = map_used;
         hd_none_nxt = map_none;
         hd_vld_nxt  = 1'b1;
      end else if (push) begin
         tl_data_nxt = map_lane;
         tl_used_nxt = map_used;
         tl_none_nxt = map_none;
         tl_vld_nxt  = 1'b1;
      end
   end

   // buffer registers
   // synchronous reset clears the valids; data is cleared too so that a
   // frame never shows stale lanes after reset
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         hd_data_r <= '0;
         hd_used_r <= '0;
         hd_none_r <= 1'b0;
         hd_vld_r  <= 1'b0;
         tl_data_r <= '0;
         tl_used_r <= '0;
         tl_none_r <= 1'b0;
         tl_vld_r  <= 1'b0;
         rdy_r     <= 1'b0;
      end else begin
         hd_data_r <= hd_data_nxt;
         hd_used_r <= hd_used_nxt;
         hd_none_r <= hd_none_nxt;
         hd_vld_r  <= hd_vld_nxt;
         tl_data_r <= tl_data_nxt;
         tl_used_r <= tl_used_nxt;
         tl_none_r <= tl_none_nxt;
         tl_vld_r  <= tl_vld_nxt;
         rdy_r     <= !tl_vld_nxt;
      end
   end

   // ports straight from the head entry, in_ready_o from rdy_r
   // every output comes straight from a register, none through logic
   // lane_used_o marks the lanes that the receiver should deframe
   assign in_ready_o      = rdy_r;
   assign lane_valid_o    = hd_vld_r;
   assign lane_data_o     = hd_data_r;
   assign lane_used_o     = hd_used_r;
   assign lane_unmapped_o = hd_none_r;

endmodule

/* hdl/dsm_params.svh */
/*
   Constants of the sample lane mapper: widths, link mode numbers and the
   lane count of each mapping. Assumes it is included by bare name.
*/
`ifndef DSM_PARAMS_SVH
`define DSM_PARAMS_SVH

`define DSM_MODE_W   7
`define DSM_SAMP_W   15
`define DSM_BYP_W    12
`define DSM_LANE_W   32
`define DSM_WORD_W   16
`define DSM_PAD_W    16
`define DSM_SIDE_N   8
`define DSM_LANE_N   16
`define DSM_COMP_N   4
`define DSM_BYP_N    8

`define DSM_LM_13 7'h0D
`define DSM_LM_39 7'h27
`define DSM_LM_56 7'h38
`define DSM_LM_59 7'h3B
`define DSM_LM_66 7'h42
`define DSM_LM_68 7'h44
`define DSM_LM_14 7'h0E
`define DSM_LM_49 7'h31
`define DSM_LM_57 7'h39
`define DSM_LM_60 7'h3C
`define DSM_LM_67 7'h43
`define DSM_LM_15 7'h0F
`define DSM_LM_55 7'h37
`define DSM_LM_58 7'h3A
`define DSM_LM_16 7'h10
`define DSM_LM_19 7'h13
`define DSM_LM_42 7'h2A
`define DSM_LM_20 7'h14
`define DSM_LM_43 7'h2B
`define DSM_LM_21 7'h15
`define DSM_LM_36 7'h24
`define DSM_LM_22 7'h16
`define DSM_LM_46 7'h2E
`define DSM_LM_23 7'h17
`define DSM_LM_38 7'h26
`define DSM_LM_61 7'h3D
`define DSM_LM_64 7'h40
`define DSM_LM_69 7'h45
`define DSM_LM_71 7'h47
`define DSM_LM_24 7'h18
`define DSM_LM_48 7'h30
`define DSM_LM_62 7'h3E
`define DSM_LM_65 7'h41
`define DSM_LM_70 7'h46

// lanes used on each side, and words per component on a side
`define DSM_LANES_1  4'h1
`define DSM_LANES_2  4'h2
`define DSM_LANES_4  4'h4
`define DSM_LANES_6  4'h6
`define DSM_LANES_8  4'h8
`define DSM_WORDS_0  4'h0
`define DSM_WORDS_1  4'h1
`define DSM_WORDS_2  4'h2
`define DSM_WORDS_4  4'h4

`endif

/* hdl/dsm_pkg.sv */
/*
   Types of the sample lane mapper.
   Assumes dsm_params.svh is on the include path.
*/
`include "dsm_params.svh"

package dsm_pkg;

   typedef logic [`DSM_MODE_W-1:0] dsm_mode_t;
   typedef logic [`DSM_SAMP_W-1:0] dsm_samp_t;
   typedef logic [`DSM_BYP_W-1:0]  dsm_byp_t;
   typedef logic [`DSM_LANE_W-1:0] dsm_lane_t;

   // mapping families selected by the link mode
   typedef enum logic [3:0] {
      DSM_DUAL_2L,
      DSM_DUAL_4L,
      DSM_DUAL_8L,
      DSM_DUAL_16L,
      DSM_BYP_SINGLE,
      DSM_BYP_DUAL,
      DSM_SING_D4_4L,
      DSM_SING_D4_8L,
      DSM_SING_D8_2L,
      DSM_SING_D8_4L,
      DSM_UNMAPPED
   } dsm_map_e;

endpackage

/* verification/dsm_lane_mapper_checker.sv */
/* port properties of the lane mapper and its two-entry buffer.
   assumes a bind onto dsm_lane_mapper and a single clock. */
`timescale 1ns/1ps
module dsm_lane_mapper_checker (
   // clock and reset
   input wire logic              clk_sys_i,
   input wire logic              rstn_i,
   // handshakes
   input wire logic              in_valid_i,
   input wire logic              in_ready_o,
   input wire logic              lane_valid_o,
   input wire logic              lane_ready_i,
   // lane contents
   input wire logic [15:0][31:0] lane_data_o,
   input wire logic [15:0]       lane_used_o,
   input wire logic              lane_unmapped_o
);
   logic [15:0][31:0] mask_w;
   // widen each used flag across its lane
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         mask_w[i] = {32{lane_used_o[i]}};
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   // reset, flow control and head hold
   AST_RST_QUIET: assert property ($rose(rstn_i) |->
      !lane_valid_o && !in_ready_o && !lane_unmapped_o) else $error("outputs live after reset");
   AST_TAKE_SHOWS: assert property (in_valid_i && in_ready_o |=> lane_valid_o)
      else $error("taken frame not shown");
   AST_HOLD: assert property (lane_valid_o && !lane_ready_i |=> lane_valid_o &&
      $stable(lane_data_o) && $stable(lane_used_o) && $stable(lane_unmapped_o))
      else $error("stalled head changed");
   AST_READY_FULL: assert property ((in_valid_i && in_ready_o && lane_valid_o &&
      !lane_ready_i) ##1 !lane_ready_i |=> !in_ready_o) else $error("third frame not refused");
   AST_POP_ADV: assert property (lane_valid_o && lane_ready_i && !in_ready_o |=>
      ##[0:1] in_ready_o) else $error("ready not back after pop");
   // lane contents against the mode shape
   AST_UNMAP_ZERO: assert property (lane_valid_o && lane_unmapped_o |->
      lane_data_o == '0 && lane_used_o == '0) else $error("unmapped frame not empty");
   AST_UNUSED_ZERO: assert property (lane_valid_o |-> (lane_data_o & ~mask_w) == '0)
      else $error("unused lane carries data");
   AST_LOW16: assert property (lane_valid_o && lane_used_o[1] |->
      lane_data_o[0][15:0] == 16'h0000) else $error("low half of lane word not zero");
   AST_USED_SHAPE: assert property (lane_valid_o && !lane_unmapped_o |-> lane_used_o
      inside {16'h0101, 16'h0303, 16'h0F0F, 16'hFFFF, 16'h3F3F}) else $error("bad lane set");
   // main scenarios reached
   cover property (lane_valid_o && lane_used_o == 16'hFFFF);
   cover property (lane_valid_o && lane_unmapped_o);
   cover property (in_valid_i && !in_ready_o);
endmodule
bind dsm_lane_mapper dsm_lane_mapper_checker chk_u (.clk_sys_i, .rstn_i, .in_valid_i,
   .in_ready_o, .lane_valid_o, .lane_ready_i, .lane_data_o, .lane_used_o, .lane_unmapped_o);

/* verification/dsm_rx_model.sv */
/* receiver model: takes whole lane frames and keeps a short log.
   assumes the bench drives stall_i off the rising edge. */
`timescale 1ns/1ps
module dsm_rx_model (
   // clock, reset, stall request
   input wire logic              clk_sys_i,
   input wire logic              rstn_i,
   input wire logic              stall_i,
   // lanes from the mapper
   input wire logic              lane_valid_i,
   input wire logic [15:0][31:0] lane_data_i,
   input wire logic [15:0]       lane_used_i,
   input wire logic              lane_unmapped_i,
   output logic                  lane_ready_o,
   // what was received
   output logic [15:0][31:0]     rx_data_o,
   output logic [15:0]           rx_used_o,
   output logic                  rx_unmapped_o,
   output logic [7:0]            rx_cnt_o,
   output logic [7:0][31:0]      rx_log_o
);
   always @(posedge clk_sys_i) begin
      lane_ready_o <= rstn_i && !stall_i;
      if (!rstn_i) begin
         rx_cnt_o <= 8'h00;
      end else if (lane_valid_i && lane_ready_o) begin
         rx_data_o <= lane_data_i;
         rx_used_o <= lane_used_i;
         rx_unmapped_o <= lane_unmapped_i;
         rx_log_o[rx_cnt_o[2:0]] <= lane_data_i[0]; // order check needs lane a0 only
         rx_cnt_o <= rx_cnt_o + 8'h01;
      end
   end
endmodule

/* verification/dsm_lane_mapper_tb.sv */
/* self-checking bench of the lane mapper with a stalling receiver.
   assumes the design files and the checker are compiled first. */
`timescale 1ns/1ps
module dsm_lane_mapper_tb;
   import dsm_pkg::*;
   logic             clk_sys_i = 1'b0;
   logic             rstn_i = 1'b0;
   logic             in_valid_i = 1'b0;
   logic             stall = 1'b0;
   dsm_mode_t        mode;
   logic [3:0][14:0] ai, aq, bi, bq;
   logic [3:0]       fa0, fa1, fb0, fb1;
   logic [7:0][11:0] ba, bb;
   logic [15:0][31:0] ed;
   logic [15:0]      eu;
   logic             eun;
   wire              in_ready_o, lane_valid_o, lane_ready, lane_unmapped_o, rx_unm;
   wire [15:0][31:0] lane_data_o, rx_data;
   wire [15:0]       lane_used_o, rx_used;
   wire [7:0]        rx_cnt;
   wire [7:0][31:0]  rx_log;
   int               bad_count = 0;
   int               n_checks = 0;
   int               cyc = 0;

   always #2.5 clk_sys_i = ~clk_sys_i;

   dsm_lane_mapper dut_u (.clk_sys_i, .rstn_i, .in_valid_i, .in_ready_o,
      .link_mode_select_i(mode), .chan_a_inphase_i(ai), .chan_a_quadrature_i(aq),
      .chan_b_inphase_i(bi), .chan_b_quadrature_i(bq), .chan_a_inphase_overrange_i(fa0),
      .chan_a_quad_overrange_i(fa1), .chan_b_inphase_overrange_i(fb0),
      .chan_b_quad_overrange_i(fb1), .byp_a_i(ba), .byp_b_i(bb), .lane_valid_o,
      .lane_ready_i(lane_ready), .lane_data_o, .lane_used_o, .lane_unmapped_o);
   dsm_rx_model rx_u (.clk_sys_i, .rstn_i, .stall_i(stall), .lane_valid_i(lane_valid_o),
      .lane_data_i(lane_data_o), .lane_used_i(lane_used_o), .lane_unmapped_i(lane_unmapped_o),
      .lane_ready_o(lane_ready), .rx_data_o(rx_data), .rx_used_o(rx_used),
      .rx_unmapped_o(rx_unm), .rx_cnt_o(rx_cnt), .rx_log_o(rx_log));

   task automatic end_sim;
      if (bad_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [511:0] got, input logic [511:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
      end
   endtask

   // a 16-bit lane word sits in the upper half of the lane
   task automatic put(input int k, input logic [15:0] v);
      ed[k] = {v, 16'h0000};
      eu[k] = 1'b1;
   endtask

   // expected frame from the inputs now held
   task automatic calc;
      int nd, ns;
      logic p13, pb;
      logic [47:0] ga, gb;
      ed = '0;
      eu = '0;
      {nd, ns, p13, pb, eun} = '0;
      case (mode)
         13, 39, 56, 59, 66, 68: p13 = 1'b1;
         14, 49, 57, 60, 67: nd = 1;
         15, 55, 58: nd = 2;
         16: nd = 4;
         19, 42, 20, 43: pb = 1'b1;
         23, 38, 61, 64, 69, 71: ns = 1;
         21, 36, 24, 48, 62, 65, 70: ns = 2;
         22, 46: ns = 4;
         default: eun = 1'b1;
      endcase
      for (int j = 0; j < nd; j++) begin
         put(j, {ai[j], fa0[j]});
         put(nd + j, {aq[j], fa1[j]});
         put(8 + j, {bi[j], fb0[j]});
         put(8 + nd + j, {bq[j], fb1[j]});
      end
      for (int j = 0; j < ns; j++) begin
         put(j, {ai[j], fa0[j]});
         put(8 + j, {aq[j], fa1[j]});
      end
      if (p13) begin
         put(0, {ai[0], fa0[0]});
         put(8, {bi[0], fb0[0]});
         ed[0][15:0] = {aq[0], fa1[0]};
         ed[8][15:0] = {bq[0], fb1[0]};
      end
      for (int g = 0; g < 2 && pb; g++) begin
         ga = {ba[4*g], ba[4*g+1], ba[4*g+2], ba[4*g+3]};
         gb = {bb[4*g], bb[4*g+1], bb[4*g+2], bb[4*g+3]};
         for (int t = 0; t < 3; t++) begin
            put(3 * g + t, ga[47 - 16 * t -: 16]);
            put(8 + 3 * g + t, gb[47 - 16 * t -: 16]);
         end
      end
   endtask

   task automatic setin(input int k, input int md);
      mode = 7'(md);
      for (int j = 0; j < 8; j++) begin
         ba[j] = 12'(12'hA00 + 12'h011 * j + k);
         bb[j] = 12'(12'h500 + 12'h013 * j + k);
      end
      for (int j = 0; j < 4; j++) begin
         ai[j] = 15'(16'h1100 + 16 * k + j);
         aq[j] = 15'(16'h2200 + 16 * k + j);
         bi[j] = 15'(16'h3300 + 16 * k + j);
         bq[j] = 15'(16'h4400 + 16 * k + j);
      end
      {fa0, fa1, fb0, fb1} = 16'h53AC ^ {4{4'(k)}};
      calc;
   endtask

   // hold the offer until the mapper is ready, then release
   task automatic offer;
      int t = 0;
      in_valid_i = 1'b1;
      while (in_ready_o !== 1'b1 && t < 50) begin
         @(negedge clk_sys_i);
         t++;
      end
      chk(t < 50, 1'b1);
      @(negedge clk_sys_i);
      in_valid_i = 1'b0;
   endtask

   task automatic push(input int k, input int md);
      @(negedge clk_sys_i);
      setin(k, md);
      offer;
   endtask

   task automatic wait_rx(input logic [7:0] n);
      int t = 0;
      while (rx_cnt !== n && t < 50) begin
         @(negedge clk_sys_i);
         t++;
      end
      chk(rx_cnt, n);
   endtask

   // every mapped mode, plus the unlisted modes 0, 10 and 127
   task automatic t_modes;
      int md [37] = '{13, 39, 56, 59, 66, 68, 14, 49, 57, 60, 67, 15, 55, 58, 16, 19, 42,
         20, 43, 21, 36, 22, 46, 23, 38, 61, 64, 69, 71, 24, 48, 62, 65, 70, 0, 10, 127};
      logic [7:0] c;
      foreach (md[i]) begin
         c = rx_cnt;
         push(i, md[i]);
         wait_rx(c + 8'h01);
         chk(rx_data, ed);
         chk({rx_used, rx_unm}, {eu, eun});
      end
   endtask

   // receiver stalls: two frames buffered, a third refused, order kept
   task automatic t_stall;
      logic [7:0] c;
      logic [2:0][31:0] e0;
      c = rx_cnt;
      stall = 1'b1;
      push(1, 16);
      e0[0] = ed[0];
      push(2, 13);
      e0[1] = ed[0];
      @(negedge clk_sys_i);
      setin(3, 19);
      e0[2] = ed[0];
      in_valid_i = 1'b1;
      repeat (3) begin
         @(negedge clk_sys_i);
         chk(in_ready_o, 1'b0);
      end
      stall = 1'b0;
      offer;
      wait_rx(c + 8'h03);
      for (int i = 0; i < 3; i++) begin
         chk(rx_log[3'(c + i)], e0[i]);
      end
   endtask

   // reset in mid-run drops a buffered frame
   task automatic t_reset;
      stall = 1'b1;
      push(5, 22);
      rstn_i = 1'b0;
      repeat (2) @(negedge clk_sys_i);
      chk({lane_valid_o, in_ready_o, lane_unmapped_o}, 3'b000);
      rstn_i = 1'b1;
      stall = 1'b0;
      repeat (2) @(negedge clk_sys_i);
      chk({lane_valid_o, in_ready_o}, 2'b01);
   endtask

   // cut a hang short
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         end_sim;
      end
   end

   initial begin
      setin(0, 0);
      repeat (20) @(negedge clk_sys_i);
      rstn_i = 1'b1;
      t_modes;
      t_stall;
      t_reset;
      end_sim;
   end
endmodule
